// file: core/tmc_pkg.sv
// Package with constants, types and enums for the thermostat mode control block
package tmc_pkg;

  // Time base: one tick per second is derived from ref_clk
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_SEC_CYCLES = CLK_HZ;
  localparam int unsigned TICK_W = 27;

  // Durations as printed, in seconds except the stage-two delay in minutes
  localparam int unsigned CHG_WINDOW_SEC = 60;
  localparam int unsigned MENU_TIMEOUT_SEC = 10;
  localparam int unsigned FAN_OFF_DELAY_SEC = 120;
  localparam int unsigned STAGE2_DELAY_MIN = 5;
  localparam int unsigned STAGE2_DELAY_SEC = STAGE2_DELAY_MIN * 60;
  localparam int unsigned SEC_W = 16;

  // Encodings written by the supervisor
  localparam logic [1:0] CTRL_SEL_COOL = 2'h1;
  localparam logic [1:0] CTRL_SEL_HEAT = 2'h2;
  localparam logic [1:0] FAN_SPEED_STOP = 2'h1;
  localparam logic [1:0] FAN_SPEED_LOW = 2'h2;

  // Values after reset
  localparam logic RST_FAN_HEAT_EN = 1'b1;
  localparam logic RST_OCCUPIED = 1'b1;
  localparam logic RST_FAN_CONT = 1'b0;

  typedef enum logic {
    TMC_MODE_HEAT = 1'b0,
    TMC_MODE_COOL = 1'b1
  } tmc_mode_e;

  // Local mode-change gesture
  typedef enum logic [1:0] {
    TMC_LM_IDLE = 2'b00,
    TMC_LM_WAIT = 2'b01
  } tmc_lm_e;

  // Panel buttons, one pulse per press
  typedef struct packed {
    logic mode;
    logic fan;
    logic up;
    logic down;
    logic set;
    logic power;
  } tmc_btn_s;

  // Stage demand from the control algorithm
  typedef struct packed {
    logic stage1;
    logic stage2;
  } tmc_demand_s;

  // Setpoints, 0.5 degree steps
  typedef logic [9:0] tmc_temp_t;

endpackage

// file: core/tmc_sec_timer.sv
// Down-counting seconds timer with load and expiry pulse
`timescale 1ns/1ns
module tmc_sec_timer #(
  parameter int unsigned W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sec_tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic stop,
  output logic running,
  output logic expired
);
  logic [W-1:0] cnt_r;

  initial begin
    if (W < 2) $error("tmc_sec_timer: W too small");
  end

  // Load wins over stop and count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        cnt_r <= load_val;
      end else if (stop) begin
        cnt_r <= '0;
      end else if (sec_tick && cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
          expired <= 1'b1;
        end
      end
    end
  end

  assign running = (cnt_r != '0);
endmodule

// file: core/tmc_btn_sync.sv
// Two-flop synchroniser and rising-edge detector for panel buttons
`timescale 1ns/1ns
module tmc_btn_sync #(
  parameter int unsigned N = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [N-1:0] pin,
  output logic [N-1:0] press
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  // First flop feeds only the second one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      press <= '0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      press <= sync_r & ~prev_r;
    end
  end
endmodule

// file: core/tmc_mode_ctrl.sv
// Thermostat mode, changeover, panel button, fan and stage control
`timescale 1ns/1ns
module tmc_mode_ctrl #(
  parameter int unsigned TICK_CYCLES = tmc_pkg::TICK_SEC_CYCLES,
  parameter int unsigned STAGE_DELAY_W = tmc_pkg::SEC_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] btn_pin,
  input wire logic [5:0] btn_lock,
  input wire logic factory_reset,
  input wire logic options_wr,
  input wire logic [7:0] options_wdata,
  input wire logic ctrl_sel_wr,
  input wire logic [1:0] ctrl_sel_wdata,
  input wire logic options_menu_set,
  input wire logic fan_heat_wr,
  input wire logic fan_heat_wdata,
  input wire logic fan_cont_wr,
  input wire logic fan_cont_wdata,
  input wire logic occ_wr,
  input wire logic occ_wdata,
  input wire logic [1:0] lowest_fan_speed,
  input wire logic display_option,
  input wire logic [STAGE_DELAY_W-1:0] cool_second_stage_delay,
  input wire logic [STAGE_DELAY_W-1:0] heat_second_stage_delay,
  input wire tmc_pkg::tmc_temp_t occupied_cool_setpoint,
  input wire tmc_pkg::tmc_temp_t occupied_heat_setpoint,
  input wire tmc_pkg::tmc_temp_t unoccupied_cool_setpoint,
  input wire tmc_pkg::tmc_temp_t unoccupied_heat_setpoint,
  input wire tmc_pkg::tmc_temp_t room_temp,
  input wire tmc_pkg::tmc_demand_s demand,
  output logic mode_cool,
  output logic [7:0] changeover_options,
  output logic chg_armed,
  output logic menu_active,
  output logic fan_cont,
  output logic fan_heat_output_enable,
  output logic occupied,
  output logic occ_pending,
  output tmc_pkg::tmc_temp_t active_setpoint,
  output tmc_pkg::tmc_temp_t display_temp,
  output logic stage1_out,
  output logic stage2_out,
  output logic fan_out,
  output logic active_ind,
  output logic stage2_ind,
  output logic auto_ind
);
  logic [tmc_pkg::TICK_W-1:0] tick_cnt_r;
  logic sec_tick;
  logic flash_r;
  logic [5:0] press_raw;
  tmc_pkg::tmc_btn_s press;
  tmc_pkg::tmc_mode_e mode_r;
  tmc_pkg::tmc_lm_e lm_r;
  logic chg_run;
  logic chg_exp;
  logic menu_exp;
  logic fan_dly_run;
  logic stg_run;
  logic stg_exp;
  logic stage2_ok_r;
  logic occ_edit_r;
  logic demand_prev_r;
  logic any_demand;
  logic chg_accept;
  logic chg_start;
  logic local_toggle;
  logic any_press;
  logic [STAGE_DELAY_W-1:0] stage_delay_sel;

  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << tmc_pkg::TICK_W))
      $error("tmc_mode_ctrl: TICK_CYCLES out of range");
    if (STAGE_DELAY_W < 9) $error("tmc_mode_ctrl: STAGE_DELAY_W too small");
  end

  // Pick a setpoint from mode and occupancy
  function automatic tmc_pkg::tmc_temp_t pick_setpoint(input logic cool, input logic occ,
      input tmc_pkg::tmc_temp_t oc, input tmc_pkg::tmc_temp_t oh,
      input tmc_pkg::tmc_temp_t uc, input tmc_pkg::tmc_temp_t uh);
    if (cool) pick_setpoint = occ ? oc : uc;
    else pick_setpoint = occ ? oh : uh;
  endfunction

  // One-second tick; a parameter so simulation can shorten it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      flash_r <= 1'b0;
    end else if (tick_cnt_r == tmc_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      flash_r <= ~flash_r;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign sec_tick = (tick_cnt_r == tmc_pkg::TICK_W'(TICK_CYCLES - 1));

  tmc_btn_sync #(.N(6)) u_btn (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(btn_pin),
    .press(press_raw)
  );

  assign press = tmc_pkg::tmc_btn_s'(press_raw & ~btn_lock);
  assign any_press = |press_raw;

  // menu timeout retriggered by any press
  tmc_sec_timer #(.W(tmc_pkg::SEC_W)) u_menu (
    .ref_clk(ref_clk),
    .rst(rst),
    .sec_tick(sec_tick),
    .load(any_press),
    .load_val(tmc_pkg::SEC_W'(tmc_pkg::MENU_TIMEOUT_SEC)),
    .stop(1'b0),
    .running(menu_active),
    .expired(menu_exp)
  );

  // window starts when options becomes 1, from the network or the menu
  assign chg_start = (options_wr ? options_wdata == 8'h01 : options_menu_set) && changeover_options != 8'h01;
  tmc_sec_timer #(.W(tmc_pkg::SEC_W)) u_chg (
    .ref_clk(ref_clk),
    .rst(rst),
    .sec_tick(sec_tick),
    .load(chg_start),
    .load_val(tmc_pkg::SEC_W'(tmc_pkg::CHG_WINDOW_SEC)),
    .stop(chg_accept),
    .running(chg_run),
    .expired(chg_exp)
  );

  // armed only while options holds 1
  assign chg_armed = chg_run && changeover_options == 8'h01;

  // a valid select while armed is accepted
  assign chg_accept = (chg_armed && ctrl_sel_wr &&
      (ctrl_sel_wdata == tmc_pkg::CTRL_SEL_COOL || ctrl_sel_wdata == tmc_pkg::CTRL_SEL_HEAT))
      || local_toggle;

  // local gesture, only after menu timed out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lm_r <= tmc_pkg::TMC_LM_IDLE;
    end else begin
      unique case (lm_r)
        tmc_pkg::TMC_LM_IDLE:
          if (chg_armed && !occ_edit_r && press.mode && !menu_active) lm_r <= tmc_pkg::TMC_LM_WAIT;
        tmc_pkg::TMC_LM_WAIT:
          if (!chg_armed || press.up || press.down || press.set || press.fan) lm_r <= tmc_pkg::TMC_LM_IDLE;
        default: lm_r <= tmc_pkg::TMC_LM_IDLE;
      endcase
    end
  end
  assign local_toggle = (lm_r == tmc_pkg::TMC_LM_WAIT) && chg_armed && (press.up || press.down);

  // mode changes only on accepted changeover; factory reset ignored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= tmc_pkg::TMC_MODE_HEAT;
    end else if (local_toggle) begin
      mode_r <= (mode_r == tmc_pkg::TMC_MODE_HEAT) ? tmc_pkg::TMC_MODE_COOL : tmc_pkg::TMC_MODE_HEAT;
    end else if (chg_accept) begin
      mode_r <= (ctrl_sel_wdata == tmc_pkg::CTRL_SEL_COOL) ? tmc_pkg::TMC_MODE_COOL : tmc_pkg::TMC_MODE_HEAT;
    end
  end
  assign mode_cool = (mode_r == tmc_pkg::TMC_MODE_COOL);

  // expiry clears options; acceptance also clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      changeover_options <= 8'h00;
    end else if (options_wr) begin
      changeover_options <= options_wdata;
    end else if (options_menu_set) begin
      changeover_options <= 8'h01;
    end else if (chg_exp || chg_accept) begin
      changeover_options <= 8'h00;
    end
  end

  // FAN press toggles; a network write in the same cycle wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fan_cont <= tmc_pkg::RST_FAN_CONT;
    end else if (fan_cont_wr) begin
      fan_cont <= fan_cont_wdata;
    end else if (press.fan) begin
      fan_cont <= ~fan_cont;
    end
  end

  // fan heat enable setting, default 1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fan_heat_output_enable <= tmc_pkg::RST_FAN_HEAT_EN;
    end else if (fan_heat_wr) begin
      fan_heat_output_enable <= fan_heat_wdata;
    end
  end

  // SET opens edit, UP/DOWN toggle pending, SET/MODE apply
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      occupied <= tmc_pkg::RST_OCCUPIED;
      occ_pending <= tmc_pkg::RST_OCCUPIED;
      occ_edit_r <= 1'b0;
    end else if (occ_wr) begin
      occupied <= occ_wdata;
      occ_pending <= occ_wdata;
      occ_edit_r <= 1'b0;
    end else if (!occ_edit_r) begin
      if (press.set) begin
        occ_edit_r <= 1'b1;
        occ_pending <= occupied;
      end
    end else if (press.set || press.mode) begin
      occupied <= occ_pending;
      occ_edit_r <= 1'b0;
    end else if (press.up || press.down) begin
      occ_pending <= ~occ_pending;
    end else if (menu_exp) begin
      occ_edit_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_setpoint <= '0;
    end else begin
      active_setpoint <= pick_setpoint(mode_cool, occupied, occupied_cool_setpoint,
          occupied_heat_setpoint, unoccupied_cool_setpoint, unoccupied_heat_setpoint);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      display_temp <= '0;
    end else begin
      display_temp <= display_option ? active_setpoint : room_temp;
    end
  end

  // second-stage delay from the stage-one start
  assign stage_delay_sel = mode_cool ? cool_second_stage_delay : heat_second_stage_delay;
  tmc_sec_timer #(.W(STAGE_DELAY_W)) u_stg (
    .ref_clk(ref_clk),
    .rst(rst),
    .sec_tick(sec_tick),
    .load(demand.stage1 && !stage1_out),
    .load_val(stage_delay_sel),
    .stop(!demand.stage1),
    .running(stg_run),
    .expired(stg_exp)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage2_ok_r <= 1'b0;
    end else if (!demand.stage1) begin
      stage2_ok_r <= 1'b0;
    end else if (stg_exp || (stage1_out && !stg_run)) begin
      stage2_ok_r <= 1'b1;
    end
  end

  // Stage outputs follow demand, stage two only after the delay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_out <= 1'b0;
      stage2_out <= 1'b0;
    end else begin
      stage1_out <= demand.stage1;
      stage2_out <= demand.stage1 && demand.stage2 && stage2_ok_r;
    end
  end

  // fan off-delay after an action ends when lowest speed is stop
  assign any_demand = demand.stage1;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) demand_prev_r <= 1'b0;
    else demand_prev_r <= any_demand;
  end
  tmc_sec_timer #(.W(tmc_pkg::SEC_W)) u_fan (
    .ref_clk(ref_clk),
    .rst(rst),
    .sec_tick(sec_tick),
    .load(demand_prev_r && !any_demand && lowest_fan_speed == tmc_pkg::FAN_SPEED_STOP),
    .load_val(tmc_pkg::SEC_W'(tmc_pkg::FAN_OFF_DELAY_SEC)),
    .stop(any_demand),
    .running(fan_dly_run),
    .expired()
  );

  // fan drive; heat cycles gated by the enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fan_out <= 1'b0;
    end else begin
      fan_out <= fan_cont || (lowest_fan_speed == tmc_pkg::FAN_SPEED_LOW) ||
          ((any_demand || demand_prev_r || fan_dly_run) && (mode_cool || fan_heat_output_enable)); // Bridges the timer load
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auto_ind <= 1'b1;
      active_ind <= 1'b0;
      stage2_ind <= 1'b0;
    end else begin
      auto_ind <= !fan_cont && (!fan_dly_run || flash_r);
      active_ind <= stage1_out || stage2_out;
      stage2_ind <= stage2_out;
    end
  end

  // Checks
  sequence s_arm;
    chg_start;
  endsequence

  AST_FACTORY_KEEPS_MODE: assert property (@(posedge ref_clk) disable iff (rst)
    (factory_reset && !chg_accept) |=> $stable(mode_r))
    else $error("mode changed by factory reset");
  AST_MODE_ONLY_ON_ACCEPT: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(chg_accept) |-> $stable(mode_r))
    else $error("mode changed without changeover");
  AST_ARMED_NEEDS_ONE: assert property (@(posedge ref_clk) disable iff (rst)
    chg_armed |-> changeover_options == 8'h01)
    else $error("armed without options 1");
  AST_ARM_STARTS: assert property (@(posedge ref_clk) disable iff (rst)
    s_arm |=> chg_run)
    else $error("window did not start");
  AST_COOL_SELECT: assert property (@(posedge ref_clk) disable iff (rst)
    (chg_armed && ctrl_sel_wr && ctrl_sel_wdata == tmc_pkg::CTRL_SEL_COOL && !local_toggle) |=> mode_cool)
    else $error("cool select not taken");
  AST_EXPIRY_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
    (chg_exp && !options_wr && !options_menu_set) |=> changeover_options == 8'h00)
    else $error("options not cleared at expiry");
  AST_FAN_TOGGLE: assert property (@(posedge ref_clk) disable iff (rst)
    (press.fan && !fan_cont_wr) |=> fan_cont != $past(fan_cont))
    else $error("fan press did not toggle");
  AST_LOCK_FAN: assert property (@(posedge ref_clk) disable iff (rst)
    (btn_lock[4] && !fan_cont_wr) |=> $stable(fan_cont))
    else $error("locked fan button acted");
  AST_STAGE2_GATED: assert property (@(posedge ref_clk) disable iff (rst)
    stage2_out |-> $past(stage2_ok_r))
    else $error("stage two before delay");
  AST_FAN_HEAT_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    (!mode_cool && !fan_heat_output_enable && !fan_cont && lowest_fan_speed != tmc_pkg::FAN_SPEED_LOW
     && $stable(mode_cool) && $stable(fan_heat_output_enable) && $stable(fan_cont)) |=> !fan_out)
    else $error("fan driven in heat while disabled");
  AST_ACTIVE_IND: assert property (@(posedge ref_clk) disable iff (rst)
    stage1_out |=> active_ind)
    else $error("active indication missing");
endmodule

// file: tb/tmc_panel_model.sv
// Partner model: network supervisor and panel user in front of the block
`timescale 1ns/1ns
module tmc_panel_model (
  input wire logic ref_clk,
  output logic [5:0] btn_pin,
  output logic options_wr,
  output logic [7:0] options_wdata,
  output logic ctrl_sel_wr,
  output logic [1:0] ctrl_sel_wdata,
  output logic options_menu_set
);
  // Idle: nothing pressed, no writes pending
  initial begin
    btn_pin = 6'h00;
    options_wr = 1'b0;
    options_wdata = 8'h00;
    ctrl_sel_wr = 1'b0;
    ctrl_sel_wdata = 2'h0;
    options_menu_set = 1'b0;
  end

  // Held four cycles so the two-flop synchroniser surely sees it
  task automatic press(input int idx);
    @(negedge ref_clk);
    btn_pin[idx] = 1'b1;
    repeat (4) @(negedge ref_clk);
    btn_pin[idx] = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic opt_write(input logic [7:0] v);
    @(negedge ref_clk);
    options_wr = 1'b1;
    options_wdata = v;
    @(negedge ref_clk);
    options_wr = 1'b0;
    options_wdata = ~v; // Stale data is not left looking valid
  endtask

  task automatic sel_write(input logic [1:0] v);
    @(negedge ref_clk);
    ctrl_sel_wr = 1'b1;
    ctrl_sel_wdata = v;
    @(negedge ref_clk);
    ctrl_sel_wr = 1'b0;
    ctrl_sel_wdata = ~v;
  endtask

  task automatic menu_set();
    @(negedge ref_clk);
    options_menu_set = 1'b1;
    @(negedge ref_clk);
    options_menu_set = 1'b0;
  endtask
endmodule

// file: tb/tmc_mode_ctrl_tb_top.sv
// Self-checking bench for the thermostat mode control block
`timescale 1ns/1ns
module tmc_mode_ctrl_tb_top;
  // One second shortened to ten clocks
  localparam int TK = 10;
  localparam tmc_pkg::tmc_temp_t OC = 10'h0c8;
  localparam tmc_pkg::tmc_temp_t OH = 10'h0a0;
  localparam tmc_pkg::tmc_temp_t UC = 10'h0f0;
  localparam tmc_pkg::tmc_temp_t UH = 10'h078;
  localparam tmc_pkg::tmc_temp_t RT = 10'h0b4;
  logic ref_clk;
  logic rst;
  logic [5:0] btn_pin, btn_lock;
  logic options_wr, ctrl_sel_wr, options_menu_set;
  logic [7:0] options_wdata, changeover_options;
  logic [1:0] ctrl_sel_wdata;
  logic [3:0] wr_v; // Pulses: factory reset, fan cont, occupancy, fan heat
  logic fan_heat_wdata, fan_cont_wdata, occ_wdata, display_option;
  logic [1:0] lowest_fan_speed = tmc_pkg::FAN_SPEED_STOP;
  logic [15:0] cool_second_stage_delay = 16'h0002;
  logic [15:0] heat_second_stage_delay = 16'h0004;
  tmc_pkg::tmc_temp_t occupied_cool_setpoint = OC;
  tmc_pkg::tmc_temp_t occupied_heat_setpoint = OH;
  tmc_pkg::tmc_temp_t unoccupied_cool_setpoint = UC;
  tmc_pkg::tmc_temp_t unoccupied_heat_setpoint = UH;
  tmc_pkg::tmc_temp_t room_temp = RT;
  tmc_pkg::tmc_temp_t active_setpoint, display_temp;
  tmc_pkg::tmc_demand_s demand;
  logic mode_cool, chg_armed, menu_active, fan_cont, fan_heat_output_enable, occupied, occ_pending;
  logic stage1_out, stage2_out, fan_out, active_ind, stage2_ind, auto_ind, flash_ref;
  int miscompares = 0;
  int check_count = 0;
  int flips;

  tmc_panel_model i_panel (.ref_clk, .btn_pin, .options_wr, .options_wdata, .ctrl_sel_wr,
    .ctrl_sel_wdata, .options_menu_set);

  tmc_mode_ctrl #(.TICK_CYCLES(TK)) i_dut (.ref_clk, .rst, .btn_pin, .btn_lock,
    .factory_reset(wr_v[0]), .options_wr, .options_wdata, .ctrl_sel_wr, .ctrl_sel_wdata,
    .options_menu_set, .fan_heat_wr(wr_v[3]), .fan_heat_wdata, .fan_cont_wr(wr_v[1]),
    .fan_cont_wdata, .occ_wr(wr_v[2]), .occ_wdata, .lowest_fan_speed, .display_option,
    .cool_second_stage_delay, .heat_second_stage_delay, .occupied_cool_setpoint,
    .occupied_heat_setpoint, .unoccupied_cool_setpoint, .unoccupied_heat_setpoint, .room_temp,
    .demand, .mode_cool, .changeover_options, .chg_armed, .menu_active, .fan_cont,
    .fan_heat_output_enable, .occupied, .occ_pending, .active_setpoint, .display_temp,
    .stage1_out, .stage2_out, .fan_out, .active_ind, .stage2_ind, .auto_ind);

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic ticks(input int n);
    cyc(n * TK);
  endtask

  // One-cycle network write strobe; data is set beforehand
  task automatic pulse(input int k);
    @(negedge ref_clk);
    wr_v[k] = 1'b1;
    @(negedge ref_clk);
    wr_v = 4'h0;
    cyc(3);
  endtask

  task automatic done(input string name);
    $display("test %0s ended, %0d checks, %0d bad", name, check_count, miscompares);
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is about 2500 cycles; a hang is cut off well beyond that
  initial begin
    repeat (12000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    btn_lock = 6'h00;
    wr_v = 4'h0;
    fan_heat_wdata = 1'b0;
    fan_cont_wdata = 1'b0;
    occ_wdata = 1'b1;
    display_option = 1'b1;
    demand = 2'b00;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    chk(mode_cool, 1'b0);
    chk({chg_armed, changeover_options}, 9'h000);
    chk({fan_heat_output_enable, fan_cont, occupied}, 3'b101);
    done("reset");
    // Select without arming, wrong options value, invalid select
    i_panel.sel_write(2'h1);
    cyc(3);
    chk(mode_cool, 1'b0);
    i_panel.opt_write(8'h02);
    cyc(2);
    chk(chg_armed, 1'b0);
    i_panel.opt_write(8'h01);
    cyc(2);
    chk({chg_armed, changeover_options}, 9'h101);
    i_panel.sel_write(2'h3);
    cyc(2);
    chk(mode_cool, 1'b0);
    i_panel.sel_write(tmc_pkg::CTRL_SEL_COOL);
    cyc(3);
    chk({mode_cool, chg_armed, changeover_options}, 10'h200);
    pulse(0);
    chk(mode_cool, 1'b1);
    chk(active_setpoint, OC);
    chk(display_temp, OC);
    done("network changeover");
    // Window runs out before any select
    i_panel.opt_write(8'h01);
    ticks(56);
    chk(chg_armed, 1'b1);
    ticks(6);
    chk({chg_armed, changeover_options}, 9'h000);
    i_panel.sel_write(tmc_pkg::CTRL_SEL_HEAT);
    cyc(3);
    chk(mode_cool, 1'b1);
    done("window expiry");
    // Fan mode toggle, lock, menu timeout, network off
    btn_lock = 6'h10;
    i_panel.press(4);
    chk(fan_cont, 1'b0);
    btn_lock = 6'h00;
    i_panel.press(4);
    chk({fan_cont, fan_out}, 2'b11);
    ticks(8);
    chk(menu_active, 1'b1);
    ticks(3);
    chk(menu_active, 1'b0);
    pulse(1);
    chk(fan_cont, 1'b0);
    fan_cont_wdata = 1'b1;
    pulse(1);
    chk({fan_cont, auto_ind}, 2'b10);
    fan_cont_wdata = 1'b0;
    pulse(1);
    chk({fan_cont, auto_ind, fan_out}, 3'b010);
    done("fan and menu");
    // Local changeover back to heating
    i_panel.menu_set();
    cyc(2);
    chk({chg_armed, changeover_options}, 9'h101);
    ticks(12);
    i_panel.press(5);
    i_panel.press(3);
    cyc(2);
    chk({mode_cool, chg_armed}, 2'b00);
    chk(active_setpoint, OH);
    done("local changeover");
    // Occupancy edit, then locked SET, then network write
    i_panel.press(1);
    i_panel.press(3);
    chk({occupied, occ_pending}, 2'b10);
    i_panel.press(1);
    cyc(2);
    chk(occupied, 1'b0);
    chk(active_setpoint, UH);
    btn_lock = 6'h02;
    i_panel.press(1);
    i_panel.press(3);
    i_panel.press(1);
    chk(occupied, 1'b0);
    btn_lock = 6'h00;
    pulse(2);
    chk({occupied, active_setpoint}, {1'b1, OH});
    occupied_heat_setpoint = 10'h0aa;
    cyc(2);
    chk(active_setpoint, 10'h0aa);
    occ_wdata = 1'b0;
    pulse(2);
    chk({occupied, occ_pending, active_setpoint}, {2'b00, UH});
    done("occupancy");
    // Heating stages with fan suppressed, then fan off-delay
    pulse(3);
    chk(fan_heat_output_enable, 1'b0);
    demand = 2'b11;
    cyc(3);
    chk({stage1_out, active_ind, fan_out, stage2_out}, 4'b1100);
    ticks(3);
    chk(stage2_out, 1'b0);
    ticks(3);
    chk({stage2_out, stage2_ind}, 2'b11);
    fan_heat_wdata = 1'b1;
    pulse(3);
    chk(fan_out, 1'b1);
    demand = 2'b00;
    cyc(3);
    chk({stage1_out, active_ind, fan_out}, 3'b001);
    flash_ref = auto_ind;
    flips = 0;
    for (int i = 0; i < 4; i++) begin
      ticks(1);
      flips += (auto_ind !== flash_ref) ? 1 : 0;
    end
    chk(flips != 0, 1'b1);
    ticks(100);
    chk(fan_out, 1'b1);
    ticks(20);
    chk(fan_out, 1'b0);
    display_option = 1'b0;
    cyc(3);
    chk(display_temp, RT);
    room_temp = 10'h0be;
    cyc(3);
    chk(display_temp, 10'h0be);
    done("stages and fan");
    // Cooling stages use their own delay; lowest speed low keeps the fan on
    i_panel.opt_write(8'h01);
    i_panel.sel_write(tmc_pkg::CTRL_SEL_COOL);
    cyc(3);
    chk({mode_cool, active_setpoint}, {1'b1, UC});
    demand = 2'b11;
    cyc(3);
    ticks(1);
    chk({stage1_out, stage2_out}, 2'b10);
    ticks(3);
    chk({stage2_out, stage2_ind, fan_out}, 3'b111);
    lowest_fan_speed = tmc_pkg::FAN_SPEED_LOW;
    demand = 2'b00;
    ticks(4);
    chk({stage1_out, fan_out}, 2'b01);
    done("cool stages");
    wrap_up();
  end
endmodule
